// >>> verilog/ovt_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          over-range and timestamp block.
// Assumes: AXI4-Lite register access, 32-bit words, byte addresses.
// Notes:   Included by its bare name; definitions only.
// Functional notes
// - Samples are 9-bit two's complement, negative when inverting input higher.
// - Over-range compares an 8-bit magnitude of each sample with threshold.
// - Magnitude maps +255/-256 to 255, +254/-254 to 254, zero to 0.
// - One threshold register serves every channel.
// - Over-range detection runs only while its enable bit is one.
// - Magnitude at or above threshold sets that channel's flag, else zero.
// - Each channel's flag drives its own output pin, channels A to D.
// - Flag stays high 8 << sel cycles after the last event, 8 to 1024.
// - The asynchronous trigger mark input is resynchronised to the clock.
// - Trigger output enabled with mode 3 repeats the retimed mark while recv_en is one.
// - Mark appears in link samples only while insertion is enabled.
// - Inserted mark replaces the sample LSB; mode 0 places sample at [11:3].
// - Mark is a 1-bit sample with latency matched to the sample path.
// - One full-scale setting applies to all inputs alike.
// - Cores swap for calibration; foreground halts sampling, background not.
`ifndef OVT_CONSTS_SVH
`define OVT_CONSTS_SVH

`define OVT_ADDR_CTRL 8'h00
`define OVT_ADDR_THRESH 8'h04
`define OVT_ADDR_FSCALE 8'h08
`define OVT_ADDR_FLAGS 8'h0C
`define OVT_ADDR_IRQ_STAT 8'h10
`define OVT_ADDR_IRQ_MASK 8'h14
`define OVT_ADDR_CAL 8'h18

`define OVT_CTRL_W 13
`define OVT_CTRL_RST 13'h0000
`define OVT_CTRL_OVERRANGE_DETECT_ENABLE 0
`define OVT_CTRL_PLEN_LSB 1
`define OVT_CTRL_TOUT_EN 4
`define OVT_CTRL_TOUT_MODE_LSB 5
`define OVT_CTRL_RECV_EN 7
`define OVT_CTRL_TS_EN 8
`define OVT_CTRL_LMODE_LSB 9

`define OVT_TOUT_MODE_MARK 2'h3
`define OVT_LMODE_ZERO 4'h0
`define OVT_THRESH_RST 8'hE4
`define OVT_FSCALE_RST 8'h00
`define OVT_IRQ_W 6
`define OVT_IRQ_RST 6'h00
`define OVT_IRQ_MARK 4
`define OVT_IRQ_CALDONE 5

`define OVT_CAL_START 0
`define OVT_CAL_BG 1
`define OVT_CAL_FG_CYCLES 10'h040
`define OVT_CAL_BG_CYCLES 10'h100
`define OVT_CORES 3'h6
`define OVT_PULSE_BASE 11'h008

`define OVT_RESP_OKAY 2'h0
`define OVT_RESP_SLVERR 2'h2

`endif

// >>> verilog/ovt_pkg.sv
// Purpose: Types shared by the over-range and timestamp block.
// Assumes: Constants come from ovt_consts.svh.
// Notes:   Types only.
package ovt_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_FORE, CAL_BACK} ovt_cal_t;
  typedef logic [3:0][8:0] ovt_samples_t;
endpackage : ovt_pkg

// >>> verilog/ovt_core.sv
// Purpose: Over-range detection, timestamp retiming and insertion, core
//          swap sequencing, with an AXI4-Lite register file.
// Assumes: Samples and valid arrive on aclk from the cores; the trigger
//          mark pin is asynchronous.
// Notes:   All outputs are flip-flops.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ovt_consts.svh"
module ovt_core (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Converted samples from the cores
  input wire logic sample_valid,
  input wire logic [8:0] sample_a,
  input wire logic [8:0] sample_b,
  input wire logic [8:0] sample_c,
  input wire logic [8:0] sample_d,
  // Trigger mark pin
  input wire logic trigger_mark_input,
  // Over-range pins
  output logic overrange_flag_ch_a,
  output logic overrange_flag_ch_b,
  output logic overrange_flag_ch_c,
  output logic overrange_flag_ch_d,
  // Trigger repeat and link words
  output logic trigger_repeat_output,
  output logic link_valid,
  output logic [11:0] link_word_a,
  output logic [11:0] link_word_b,
  output logic [11:0] link_word_c,
  output logic [11:0] link_word_d,
  // Converter control
  output logic [7:0] full_scale_setting,
  output logic sampling_halt,
  output logic [2:0] core_select,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Saturating 8-bit magnitude of a 9-bit two's complement sample
  function automatic logic [7:0] ovt_mag(input logic [8:0] s);
    logic [8:0] n;
    n = 9'h000 - s;
    if (!s[8])
      ovt_mag = s[7:0];
    else if (s == 9'h100)
      ovt_mag = 8'hFF;
    else
      ovt_mag = n[7:0];
  endfunction : ovt_mag

  // Places a sample in the link word, mark replacing its LSB
  function automatic logic [11:0] ovt_pack(input logic [8:0] s,
      input logic mark, input logic ins, input logic [3:0] lmode);
    logic [8:0] v;
    v = ins ? {s[8:1], mark} : s;
    if (lmode == `OVT_LMODE_ZERO)
      ovt_pack = {v, 3'h0};
    else
      ovt_pack = {3'h0, v};
  endfunction : ovt_pack

  // Byte-lane merge of a write
  function automatic logic [31:0] ovt_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    ovt_merge = r;
  endfunction : ovt_merge

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  logic have_aw_q, have_w_q, wr_fire;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [`OVT_CTRL_W-1:0] ctrl_q;
  logic [7:0] thresh_q;
  logic [`OVT_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic cal_bg_q, cal_start;
  logic [3:0] flag_q;
  ovt_pkg::ovt_cal_t cal_state_q;
  logic [31:0] rd_word;
  logic rd_ok;

  assign wr_fire = have_aw_q && have_w_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `OVT_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        have_aw_q <= 1'b1;
        waddr_q <= awaddr;
        awready <= 1'b0;
      end else if (!have_aw_q && !bvalid && !wr_fire) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        have_w_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
      end else if (!have_w_q && !bvalid && !wr_fire) begin
        wready <= 1'b1;
      end
      if (wr_fire) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (waddr_q[7:2] <= `OVT_ADDR_CAL >> 2 &&
                  waddr_q != `OVT_ADDR_FLAGS) ?
                 `OVT_RESP_OKAY : `OVT_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case ({araddr[7:2], 2'h0})
      `OVT_ADDR_CTRL: rd_word[`OVT_CTRL_W-1:0] = ctrl_q;
      `OVT_ADDR_THRESH: rd_word[7:0] = thresh_q;
      `OVT_ADDR_FSCALE: rd_word[7:0] = full_scale_setting;
      `OVT_ADDR_FLAGS: rd_word[7:0] = {cal_state_q, sampling_halt,
                                       trigger_repeat_output, flag_q};
      `OVT_ADDR_IRQ_STAT: rd_word[`OVT_IRQ_W-1:0] = irq_stat_q;
      `OVT_ADDR_IRQ_MASK: rd_word[`OVT_IRQ_W-1:0] = irq_mask_q;
      `OVT_ADDR_CAL: rd_word[`OVT_CAL_BG] = cal_bg_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `OVT_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? `OVT_RESP_OKAY : `OVT_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [31:0] ctrl_new, thr_new, fs_new, cal_new, w1c;
  assign ctrl_new = ovt_merge({19'h0, ctrl_q}, wdata_q, wstrb_q);
  assign thr_new = ovt_merge({24'h0, thresh_q}, wdata_q, wstrb_q);
  assign fs_new = ovt_merge({24'h0, full_scale_setting}, wdata_q, wstrb_q);
  assign cal_new = ovt_merge(32'h0000_0000, wdata_q, wstrb_q);
  assign w1c = cal_new;
  assign cal_start = wr_fire && waddr_q == `OVT_ADDR_CAL &&
                     cal_new[`OVT_CAL_START];

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ctrl_q <= `OVT_CTRL_RST;
    else if (wr_fire && waddr_q == `OVT_ADDR_CTRL)
      ctrl_q <= ctrl_new[`OVT_CTRL_W-1:0];
  end

  // One threshold for all channels keeps their flags comparable
  always_ff @(posedge aclk) begin
    if (!aresetn)
      thresh_q <= `OVT_THRESH_RST;
    else if (wr_fire && waddr_q == `OVT_ADDR_THRESH)
      thresh_q <= thr_new[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      full_scale_setting <= `OVT_FSCALE_RST;
    else if (wr_fire && waddr_q == `OVT_ADDR_FSCALE)
      full_scale_setting <= fs_new[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      cal_bg_q <= 1'b0;
    else if (wr_fire && waddr_q == `OVT_ADDR_CAL)
      cal_bg_q <= cal_new[`OVT_CAL_BG];
  end

  wire overrange_detect_enable = ctrl_q[`OVT_CTRL_OVERRANGE_DETECT_ENABLE];
  wire [2:0] plen_sel = ctrl_q[`OVT_CTRL_PLEN_LSB +: 3];
  wire tout_en = ctrl_q[`OVT_CTRL_TOUT_EN];
  wire [1:0] tout_mode = ctrl_q[`OVT_CTRL_TOUT_MODE_LSB +: 2];
  wire recv_en = ctrl_q[`OVT_CTRL_RECV_EN];
  wire ts_en = ctrl_q[`OVT_CTRL_TS_EN];
  wire [3:0] lmode = ctrl_q[`OVT_CTRL_LMODE_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////
  // Calibration core swapping

  logic [9:0] cal_cnt_q;
  logic cal_done;
  assign cal_done = cal_state_q == ovt_pkg::CAL_FORE && cal_cnt_q == 10'h000;

  // Foreground halts sampling; background rotates cores without a gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_state_q <= ovt_pkg::CAL_IDLE;
      cal_cnt_q <= 10'h000;
      sampling_halt <= 1'b0;
      core_select <= 3'h0;
    end else begin
      unique case (cal_state_q)
        ovt_pkg::CAL_IDLE: begin
          if (cal_start && !cal_new[`OVT_CAL_BG]) begin
            cal_state_q <= ovt_pkg::CAL_FORE;
            cal_cnt_q <= `OVT_CAL_FG_CYCLES - 10'h001;
            sampling_halt <= 1'b1;
          end else if (cal_start) begin
            cal_state_q <= ovt_pkg::CAL_BACK;
            cal_cnt_q <= `OVT_CAL_BG_CYCLES - 10'h001;
          end
        end
        ovt_pkg::CAL_FORE: begin
          cal_cnt_q <= cal_cnt_q - 10'h001;
          if (cal_done) begin
            cal_state_q <= ovt_pkg::CAL_IDLE;
            sampling_halt <= 1'b0;
          end
        end
        ovt_pkg::CAL_BACK: begin
          if (!cal_bg_q) begin
            cal_state_q <= ovt_pkg::CAL_IDLE;
          end else if (cal_cnt_q == 10'h000) begin
            cal_cnt_q <= `OVT_CAL_BG_CYCLES - 10'h001;
            core_select <= (core_select == `OVT_CORES - 3'h1) ?
                           3'h0 : core_select + 3'h1;
          end else begin
            cal_cnt_q <= cal_cnt_q - 10'h001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Over-range detection

  ovt_pkg::ovt_samples_t smp;
  logic smp_ok;
  logic [3:0] hit;
  logic [9:0] pcnt_q [4];
  logic [10:0] plen;
  assign smp = {sample_d, sample_c, sample_b, sample_a};
  assign smp_ok = sample_valid && !sampling_halt;
  assign plen = `OVT_PULSE_BASE << plen_sel;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      hit[c] = overrange_detect_enable && smp_ok &&
               ovt_mag(smp[c]) >= thresh_q;
    end
  end

  // Counter holds remaining cycles after the flag's first one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 4'h0;
      for (int c = 0; c < 4; c++)
        pcnt_q[c] <= 10'h000;
    end else begin
      for (int c = 0; c < 4; c++) begin
        flag_q[c] <= hit[c] || pcnt_q[c] != 10'h000;
        if (hit[c])
          pcnt_q[c] <= plen[9:0] - 10'h001;
        else if (pcnt_q[c] != 10'h000)
          pcnt_q[c] <= pcnt_q[c] - 10'h001;
      end
    end
  end

  assign overrange_flag_ch_a = flag_q[0];
  assign overrange_flag_ch_b = flag_q[1];
  assign overrange_flag_ch_c = flag_q[2];
  assign overrange_flag_ch_d = flag_q[3];

  ////////////////////////////////////////////////////////////////////////
  // Timestamp path

  logic mark_m1_q, mark_m2_q, mark_q, mark;
  ovt_pkg::ovt_samples_t smp_d1_q, smp_d2_q;
  logic ok_d1_q, ok_d2_q;
  assign mark = mark_m2_q && recv_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mark_m1_q <= 1'b0;
      mark_m2_q <= 1'b0;
      mark_q <= 1'b0;
    end else begin
      mark_m1_q <= trigger_mark_input;
      mark_m2_q <= mark_m1_q;
      mark_q <= mark;
    end
  end

  // Samples wait out the two synchroniser stages so mark and data align
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_d1_q <= '0;
      smp_d2_q <= '0;
      ok_d1_q <= 1'b0;
      ok_d2_q <= 1'b0;
    end else begin
      smp_d1_q <= smp;
      smp_d2_q <= smp_d1_q;
      ok_d1_q <= smp_ok;
      ok_d2_q <= ok_d1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_valid <= 1'b0;
      link_word_a <= 12'h000;
      link_word_b <= 12'h000;
      link_word_c <= 12'h000;
      link_word_d <= 12'h000;
      trigger_repeat_output <= 1'b0;
    end else begin
      link_valid <= ok_d2_q;
      link_word_a <= ovt_pack(smp_d2_q[0], mark, ts_en, lmode);
      link_word_b <= ovt_pack(smp_d2_q[1], mark, ts_en, lmode);
      link_word_c <= ovt_pack(smp_d2_q[2], mark, ts_en, lmode);
      link_word_d <= ovt_pack(smp_d2_q[3], mark, ts_en, lmode);
      trigger_repeat_output <= tout_en && tout_mode == `OVT_TOUT_MODE_MARK
                               && mark;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irq_set = {cal_done, mark && !mark_q, hit & ~flag_q};

  // A new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_stat_q <= `OVT_IRQ_RST;
    else if (wr_fire && waddr_q == `OVT_ADDR_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~w1c[`OVT_IRQ_W-1:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_mask_q <= `OVT_IRQ_RST;
    else if (wr_fire && waddr_q == `OVT_ADDR_IRQ_MASK)
      irq_mask_q <= cal_new[`OVT_IRQ_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  flag_sets_a: assert property (hit[0] |=> overrange_flag_ch_a)
    else $error("flag A not set after hit");
  pulse_len8_a: assert property (
    (hit[1] && plen_sel == 3'h0) ##1 (!hit[1])[*8] |=> !overrange_flag_ch_b)
    else $error("pulse length 8 not honoured");
  pulse_hold_a: assert property (
    (hit[2] && plen_sel == 3'h0) ##1 (!hit[2])[*6] |-> overrange_flag_ch_c)
    else $error("pulse dropped early");
  detect_off_a: assert property (!overrange_detect_enable |-> hit == 4'h0)
    else $error("hit while detection disabled");
  mag_ends_a: assert property (sample_valid && !sampling_halt && overrange_detect_enable &&
    sample_d == 9'h100 |=> overrange_flag_ch_d)
    else $error("full negative code not 255");
  trig_rep_a: assert property (
    tout_en && tout_mode == 2'h3 && recv_en && $stable(ctrl_q)
    ##1 $stable(ctrl_q) |-> trigger_repeat_output == $past(mark_m2_q))
    else $error("trigger not repeated");
  ts_insert_a: assert property (ts_en && lmode == 4'h0 |=>
    link_word_a[3] == $past(mark) && link_word_a[2:0] == 3'h0)
    else $error("mark not in sample LSB");
  ts_absent_a: assert property (!ts_en && lmode == 4'h0 |=>
    link_word_b[11:3] == $past(smp_d2_q[1]))
    else $error("sample altered without insertion");
  latency_a: assert property (sample_valid && !sampling_halt |-> ##3 link_valid)
    else $error("sample latency mismatch");
  fg_halt_a: assert property (cal_start && !cal_bg_q && !cal_new[1] &&
    cal_state_q == ovt_pkg::CAL_IDLE |=> sampling_halt [*8])
    else $error("foreground did not halt");
  irq_level_a: assert property (|(irq_stat_q & irq_mask_q) |=> irq)
    else $error("irq not raised");

endmodule : ovt_core
`default_nettype wire

// >>> tb/ovt_sink.sv
// Purpose: Downstream logic model fed by the flag pins and link stream.
// Assumes: Runs on the same clock as the converter side.
// Notes:   Cuts gain on any flag, restores it on a clean sample.
`timescale 1ns/1ps
`default_nettype none
module ovt_sink (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stream and flags from the converter
  input wire logic link_valid,
  input wire logic [3:0] flags,
  // Observed state
  output logic gain_cut,
  output logic [15:0] words
);
  logic gain_cut_q;
  logic [15:0] words_q;
  // Gain returns only once a sample arrives with every flag low
  always_ff @(posedge aclk) begin
    if (!aresetn) gain_cut_q <= 1'b0;
    else if (|flags) gain_cut_q <= 1'b1;
    else if (link_valid) gain_cut_q <= 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) words_q <= 16'h0000;
    else if (link_valid) words_q <= words_q + 16'h0001;
  end
  assign gain_cut = gain_cut_q;
  assign words = words_q;
endmodule : ovt_sink
`default_nettype wire

// >>> tb/ovt_core_tb.sv
// Purpose: Self-checking bench for the over-range and timestamp block.
// Assumes: Register map from ovt_consts.svh, AXI4-Lite master tasks.
// Notes:   Scenarios run in sequence; a watchdog cuts a hang short.
`timescale 1ns/1ps
`default_nettype none
`include "ovt_consts.svh"
module ovt_core_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sample_valid, link_valid;
  logic [7:0] awaddr, araddr, full_scale_setting;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [8:0] sample_a, sample_b, sample_c, sample_d;
  logic trigger_mark_input, trigger_repeat_output, sampling_halt, irq;
  logic overrange_flag_ch_a, overrange_flag_ch_b;
  logic overrange_flag_ch_c, overrange_flag_ch_d;
  logic [11:0] link_word_a, link_word_b, link_word_c, link_word_d;
  logic [2:0] core_select;
  logic [3:0] flags;
  logic gain_cut;
  logic [15:0] words;
  int n_errors, comparisons;
  assign flags = {overrange_flag_ch_d, overrange_flag_ch_c,
                  overrange_flag_ch_b, overrange_flag_ch_a};
  ovt_core ovt_core_inst (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .sample_valid, .sample_a, .sample_b, .sample_c, .sample_d,
    .trigger_mark_input, .overrange_flag_ch_a, .overrange_flag_ch_b,
    .overrange_flag_ch_c, .overrange_flag_ch_d, .trigger_repeat_output,
    .link_valid, .link_word_a, .link_word_b, .link_word_c, .link_word_d,
    .full_scale_setting, .sampling_halt, .core_select, .irq);
  ovt_sink ovt_sink_inst (.aclk, .aresetn, .link_valid, .flags, .gain_cut,
    .words);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // Address and data go out together; each drops once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic put(input logic [8:0] v, input logic [3:0] m);
    @(posedge aclk);
    sample_a <= m[0] ? v : 9'h000;
    sample_b <= m[1] ? v : 9'h000;
    sample_c <= m[2] ? v : 9'h000;
    sample_d <= m[3] ? v : 9'h000;
  endtask : put
  task automatic hit(input logic [8:0] v, input logic [3:0] m);
    put(v, m);
    put(9'h000, 4'h0);
  endtask : hit
  // Counts flag A high cycles and collects every flag seen in the window
  task automatic cnt(input int n, output int c, output logic [3:0] s);
    c = 0;
    s = 4'h0;
    repeat (n) begin
      #1;
      c += int'(overrange_flag_ch_a);
      s |= flags;
      @(posedge aclk);
    end
  endtask : cnt
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(`OVT_ADDR_CTRL, d, r);
    chk(d, 32'h0000_0000);
    chk(r, `OVT_RESP_OKAY);
    rd(`OVT_ADDR_THRESH, d, r);
    chk(d, `OVT_THRESH_RST);
    rd(8'h1C, d, r);
    chk(r, `OVT_RESP_SLVERR);
    wr(`OVT_ADDR_FLAGS, 32'hF, r);
    chk(r, `OVT_RESP_SLVERR);
    wr(`OVT_ADDR_FSCALE, 32'h5A, r);
    rd(`OVT_ADDR_FSCALE, d, r);
    chk(d, 32'h0000_005A);
    chk(full_scale_setting, 8'h5A);
  endtask : t_regs
  task automatic t_mag();
    logic [1:0] r;
    int c;
    logic [3:0] s;
    logic [8:0] v [7] = '{9'h0FF, 9'h0FE, 9'h000, 9'h102, 9'h100, 9'h0FD,
                          9'h103};
    logic [3:0] e [7] = '{4'hF, 4'hF, 4'h0, 4'hF, 4'hF, 4'h0, 4'h0};
    wr(`OVT_ADDR_THRESH, 32'hFE, r);
    wr(`OVT_ADDR_CTRL, 32'h1, r);
    foreach (v[i]) begin
      hit(v[i], 4'hF);
      cnt(12, c, s);
      chk(s, e[i]);
    end
    hit(9'h0FF, 4'h2);
    cnt(12, c, s);
    chk(s, 4'h2);
    wr(`OVT_ADDR_CTRL, 32'h0, r);
    hit(9'h100, 4'hF);
    cnt(12, c, s);
    chk(s, 4'h0);
  endtask : t_mag
  task automatic t_len();
    logic [1:0] r;
    int c;
    int c2;
    logic [3:0] s;
    for (int n = 0; n < 8; n++) begin
      wr(`OVT_ADDR_CTRL, 32'(1 + 2 * n), r);
      hit(9'h100, 4'h1);
      cnt((8 << n) + 8, c, s);
      chk(c, 8 << n);
    end
    wr(`OVT_ADDR_CTRL, 32'h1, r);
    hit(9'h100, 4'h1);
    cnt(4, c, s);
    hit(9'h100, 4'h1);
    cnt(20, c2, s);
    chk(c + c2, 12);
  endtask : t_len
  // Mark and sample change at one edge, so the words show the matching
  task automatic t_mark();
    logic [1:0] r;
    int c;
    wr(`OVT_ADDR_CTRL, 32'h1F0, r);
    put(9'h0A4, 4'hF);
    repeat (6) @(posedge aclk);
    put(9'h15A, 4'hF);
    trigger_mark_input <= 1'b1;
    repeat (2) @(posedge aclk);
    #1 chk(trigger_repeat_output, 0);
    chk(link_word_a, 12'h520);
    @(posedge aclk);
    #1 chk(trigger_repeat_output, 1);
    chk(link_word_a, 12'hAD8);
    chk({link_word_c, link_word_b}, 24'hAD8AD8);
    chk(link_word_d, 12'hAD8);
    c = 0;
    repeat (8) begin
      @(posedge aclk);
      #1 c += int'(link_word_a === 12'hAD8);
      chk(link_word_a, 12'hAD8);
    end
    chk(c, 8);
    for (int m = 0; m < 3; m++) begin
      wr(`OVT_ADDR_CTRL, 32'h190 | 32'(m << 5), r);
      repeat (4) @(posedge aclk);
      #1 chk(trigger_repeat_output, 0);
    end
    wr(`OVT_ADDR_CTRL, 32'h3F0, r);
    repeat (4) @(posedge aclk);
    #1 chk(link_word_a, 12'h15B);
    wr(`OVT_ADDR_CTRL, 32'h0F0, r);
    repeat (4) @(posedge aclk);
    #1 chk(link_word_a, 12'hAD0);
    wr(`OVT_ADDR_CTRL, 32'h170, r);
    repeat (4) @(posedge aclk);
    #1 chk({trigger_repeat_output, link_word_a}, 13'h0AD0);
    put(9'h000, 4'h0);
    trigger_mark_input <= 1'b0;
  endtask : t_mark
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    int c;
    logic [3:0] s;
    wr(`OVT_ADDR_CTRL, 32'h1, r);
    wr(`OVT_ADDR_IRQ_STAT, 32'h3F, r);
    wr(`OVT_ADDR_IRQ_MASK, 32'h1, r);
    hit(9'h0FF, 4'h1);
    cnt(3, c, s);
    #1 chk(irq, 1);
    chk(gain_cut, 1);
    wr(`OVT_ADDR_IRQ_STAT, 32'h1, r);
    cnt(12, c, s);
    rd(`OVT_ADDR_IRQ_STAT, d, r);
    chk({irq, d[3:0]}, 5'h0);
    wr(`OVT_ADDR_IRQ_MASK, 32'h0, r);
    hit(9'h0FF, 4'h8);
    cnt(12, c, s);
    rd(`OVT_ADDR_IRQ_STAT, d, r);
    chk({irq, d[3:0]}, 5'h8);
  endtask : t_irq
  task automatic t_cal();
    logic [31:0] d;
    logic [1:0] r;
    int c;
    logic [3:0] s;
    wr(`OVT_ADDR_CAL, 32'h1, r);
    @(posedge aclk);
    #1 chk(sampling_halt, 1);
    hit(9'h100, 4'hF);
    cnt(12, c, s);
    chk(s, 4'h0);
    c = 0;
    while (sampling_halt && c < 200) begin
      @(posedge aclk);
      c++;
    end
    rd(`OVT_ADDR_IRQ_STAT, d, r);
    chk({sampling_halt, d[5]}, 2'h1);
    wr(`OVT_ADDR_CAL, 32'h3, r);
    repeat (300) @(posedge aclk);
    rd(`OVT_ADDR_CAL, d, r);
    chk({sampling_halt, core_select, d[1]}, 5'h3);
    wr(`OVT_ADDR_CAL, 32'h0, r);
    chk({gain_cut, words != 16'h0000}, 2'h1);
  endtask : t_cal
  //////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {sample_a, sample_b, sample_c, sample_d} = 36'h0;
    sample_valid = 1'b1;
    trigger_mark_input = 1'b0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_mag();
    t_len();
    t_mark();
    t_irq();
    t_cal();
    close_out();
  end
endmodule : ovt_core_tb
`default_nettype wire
